// ### core/pwm_osc_consts.vh
`ifndef PWM_OSC_CONSTS_VH
`define PWM_OSC_CONSTS_VH
// Selection code layout
`define SEL_W 4
`define SEL_INV_BIT 3
// Clamp versions
`define VER_FULL 2'h0
`define VER_BOTH 2'h1
`define VER_LOW_OPEN 2'h2
`define VER_HIGH_OPEN 2'h3
// Duty scale: duty_in is a fraction of 256
`define DUTY_W 8
`define DUTY_LIN_LO 8'h00
`define DUTY_LIN_HI 8'hFF
`define DUTY_CLAMP_LO 8'h0D
`define DUTY_CLAMP_HI 8'hF3
// Start-up and code filter timing in base periods
`define START_PERIODS 500
`define FILT_MULT 16
`define FILT_OFFS 6
// Base oscillator limit
`define BASE_MAX_HZ 1000000
`define SYS_CLK_HZ 50000000
`endif

// ### core/divided_pwm_oscillator.v
`timescale 1ns/100ps
`include "pwm_osc_consts.vh"

// Function
// - The 4-bit selection code comes from a quantised divider pin value relative to supply.
// - The top bit of the selection code inverts the PWM waveform before the output.
// - The base rate is divided by 1, 4, 16, 64, 256, 1024, 4096 or 16384 per output period.
// - Codes 0-7 give plain output with rising ratios, codes 8-15 inverted with mirrored ratios.
// - The base oscillator driving divider and PWM runs at no more than 1 MHz.
// - Duty tracks the input linearly and clamps at 5%/95% or reaches 0%/100% per version, except full scale at ratio 16384 gives 0%.
// - The output stops toggling when the rate-set current is too small to clock the oscillator.
// - Once started, a changed code is adopted only after 16*(difference+6) stable base periods, glitch free.
// - After reset the output stays low for 500 base periods before oscillating.
// - Inversion is a plain logic inversion applied after clamping.
module divided_pwm_oscillator #(
  parameter BASE_DIV = 50,
  parameter [1:0] VERSION = `VER_FULL
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Quantised divider pin code, asynchronous
  input wire [`SEL_W-1:0] divider_select_code,
  // Rate-set current valid, asynchronous
  input wire rate_set_current_ok,
  // Duty control, fraction of 256
  input wire [`DUTY_W-1:0] duty_in,
  // Output and state
  output reg pwm_out,
  output wire [`SEL_W-1:0] active_code,
  output wire started
);

  localparam MIN_DIV = `SYS_CLK_HZ / `BASE_MAX_HZ;
  localparam EFF_DIV = (BASE_DIV < MIN_DIV) ? MIN_DIV : BASE_DIV;
  localparam STATE_START = 1'b0;
  localparam STATE_RUN = 1'b1;

  reg [`SEL_W-1:0] code_s1_reg, code_s2_reg, code_s3_reg;
  reg ok_s1_reg, ok_s2_reg, ok_s3_reg, ok_reg;
  reg [`SEL_W-1:0] stable_code_reg;
  reg [`SEL_W-1:0] cand_reg, cand_next;
  reg [`SEL_W-1:0] act_reg;
  reg [9:0] filt_cnt_reg;
  reg [15:0] pre_cnt_reg;
  reg [13:0] per_cnt_reg;
  reg [9:0] start_cnt_reg;
  reg state_reg;
  wire tick;
  wire [3:0] diff;
  wire [31:0] filt_full;
  wire [9:0] filt_target;
  wire [2:0] ratio_idx;
  wire [13:0] per_max;
  reg [`DUTY_W-1:0] duty_c;
  wire [21:0] duty_prod;
  wire raw_high;
  wire period_end;

  // Pin synchronisers, three stages, change taken once stages 2 and 3 agree
  always @(posedge sys_clk) begin
    if (!nrst) begin
      code_s1_reg <= 4'h0;
      code_s2_reg <= 4'h0;
      code_s3_reg <= 4'h0;
      stable_code_reg <= 4'h0;
      ok_s1_reg <= 1'b0;
      ok_s2_reg <= 1'b0;
      ok_s3_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      code_s1_reg <= divider_select_code;
      code_s2_reg <= code_s1_reg;
      code_s3_reg <= code_s2_reg;
      if (code_s2_reg == code_s3_reg) begin
        stable_code_reg <= code_s3_reg;
      end
      ok_s1_reg <= rate_set_current_ok;
      ok_s2_reg <= ok_s1_reg;
      ok_s3_reg <= ok_s2_reg;
      if (ok_s2_reg == ok_s3_reg) begin
        ok_reg <= ok_s3_reg;
      end
    end
  end

  // Base oscillator enable, stopped without valid rate-set current
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pre_cnt_reg <= 16'h0000;
    end else if (!ok_reg) begin
      pre_cnt_reg <= 16'h0000;
    end else if (pre_cnt_reg == EFF_DIV - 1) begin
      pre_cnt_reg <= 16'h0000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 16'h0001;
    end
  end
  assign tick = ok_reg && (pre_cnt_reg == EFF_DIV - 1);

  // Code filter: candidate must hold for 16*(diff+6) base periods
  assign diff = (cand_reg > act_reg) ? (cand_reg - act_reg) : (act_reg - cand_reg);
  // Target peaks at 336 ticks, so ten bits are kept
  assign filt_full = `FILT_MULT * ({28'h0000000, diff} + `FILT_OFFS);
  assign filt_target = filt_full[9:0];

  // Candidate follows the synchronised pins

  always @* begin
    cand_next = cand_reg;
    if (stable_code_reg != cand_reg) begin
      cand_next = stable_code_reg;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      cand_reg <= 4'h0;
      act_reg <= 4'h0;
      filt_cnt_reg <= 10'h000;
      start_cnt_reg <= 10'h000;
      state_reg <= STATE_START;
    end else begin
      cand_reg <= cand_next;
      case (state_reg)
        // Code follows the pins until the output is enabled
        STATE_START: begin
          act_reg <= stable_code_reg;
          if (tick) begin
            if (start_cnt_reg == `START_PERIODS - 1) begin
              state_reg <= STATE_RUN;
            end else begin
              start_cnt_reg <= start_cnt_reg + 10'h001;
            end
          end
        end
        // Intermediate codes restart the count
        // New code switches only at a period end, so no short pulse
        STATE_RUN: begin
          if (cand_next != cand_reg || cand_reg == act_reg) begin
            filt_cnt_reg <= 10'h000;
          end else if (tick) begin
            if (filt_cnt_reg >= filt_target - 10'h001 && period_end) begin
              act_reg <= cand_reg;
              filt_cnt_reg <= 10'h000;
            end else if (filt_cnt_reg < filt_target - 10'h001) begin
              filt_cnt_reg <= filt_cnt_reg + 10'h001;
            end
          end
        end
        default: state_reg <= STATE_START;
      endcase
    end
  end

  // Ratio index mirrored for inverted codes
  assign ratio_idx = act_reg[`SEL_INV_BIT] ? ~act_reg[2:0] : act_reg[2:0];
  assign per_max = ((14'h0001 << {ratio_idx, 1'b0}) - 14'h0001);
  assign period_end = (per_cnt_reg == per_max);

  // Period counter, held at zero until start-up is done
  always @(posedge sys_clk) begin
    if (!nrst) begin
      per_cnt_reg <= 14'h0000;
    end else if (state_reg != STATE_RUN) begin
      per_cnt_reg <= 14'h0000;
    end else if (tick) begin
      per_cnt_reg <= period_end ? 14'h0000 : per_cnt_reg + 14'h0001;
    end
  end

  // Clamp per version
  always @* begin
    duty_c = duty_in;
    case (VERSION)
      `VER_BOTH: begin
        if (duty_in < `DUTY_CLAMP_LO) duty_c = `DUTY_CLAMP_LO;
        if (duty_in > `DUTY_CLAMP_HI) duty_c = `DUTY_CLAMP_HI;
      end
      `VER_LOW_OPEN: begin
        if (duty_in > `DUTY_CLAMP_HI) duty_c = `DUTY_CLAMP_HI;
      end
      `VER_HIGH_OPEN: begin
        if (duty_in < `DUTY_CLAMP_LO) duty_c = `DUTY_CLAMP_LO;
      end
      default: duty_c = duty_in;
    endcase
  end

  // Duty share scaled by the period length, in 1/256 steps
  // Full-scale input means 100% in VER_FULL and VER_HIGH_OPEN but 0% at ratio 16384, as duty_prod wraps; the other versions clamp it to DUTY_CLAMP_HI
  assign duty_prod = (duty_c == `DUTY_LIN_HI && VERSION != `VER_BOTH &&
                      VERSION != `VER_LOW_OPEN) ?
                     {per_max, 8'h00} + 22'h000100 :
                     ({8'h00, per_max} + 22'h000001) * {14'h0000, duty_c};
  assign raw_high = ({per_cnt_reg, 8'h00} < duty_prod);

  // Output register, low through start-up
  // Inversion sits after the clamp
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pwm_out <= 1'b0;
    end else if (state_reg != STATE_RUN) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= raw_high ^ act_reg[`SEL_INV_BIT];
    end
  end

  // Status outputs straight from registers
  assign active_code = act_reg;
  assign started = state_reg;

endmodule

// ### testbench/divided_pwm_oscillator_chk.sv
`timescale 1ns/100ps
module pwm_chk #(parameter BASE_DIV = 50, parameter [1:0] VERSION = 2'h0) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Inputs
  input wire [3:0] divider_select_code,
  input wire rate_set_current_ok,
  input wire [7:0] duty_in,
  // Outputs
  input wire pwm_out,
  input wire [3:0] active_code,
  input wire started
);
  int n_clk;
  int n_stab;
  always @(posedge sys_clk) begin
    n_clk <= nrst ? n_clk + 1 : 0;
    n_stab <= $changed(divider_select_code) ? 0 : n_stab + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_hold(d, inv);
    (started && duty_in == d && active_code[3] == inv)[*3];
  endsequence
  property p_low; !started |-> !pwm_out; endproperty
  a_low: assert property (p_low) else $error("output high before start");
  property p_keep; started |=> started; endproperty
  a_keep: assert property (p_keep) else $error("start flag dropped");
  property p_time; $rose(started) |-> n_clk >= 500 * BASE_DIV; endproperty
  a_time: assert property (p_time) else $error("start too early");
  property p_frz; (!rate_set_current_ok)[*8] |=> $stable(pwm_out); endproperty
  a_frz: assert property (p_frz) else $error("output moved without clock");
  property p_adopt;
    started && $past(started) && $changed(active_code)
      |-> n_stab >= 112 * BASE_DIV && active_code == divider_select_code;
  endproperty
  a_adopt: assert property (p_adopt) else $error("code adopted early");
  property p_full; s_hold(8'hFF, 1'b0) |-> VERSION != 0 || pwm_out; endproperty
  a_full: assert property (p_full) else $error("full duty not high");
  property p_zero; s_hold(8'h00, 1'b0) |-> VERSION != 0 || !pwm_out; endproperty
  a_zero: assert property (p_zero) else $error("zero duty not low");
  property p_inv; s_hold(8'h00, 1'b1) |-> VERSION != 0 || pwm_out; endproperty
  a_inv: assert property (p_inv) else $error("inverted zero not high");
endmodule
bind divided_pwm_oscillator pwm_chk #(.BASE_DIV(BASE_DIV), .VERSION(VERSION)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .divider_select_code(divider_select_code),
  .rate_set_current_ok(rate_set_current_ok), .duty_in(duty_in), .pwm_out(pwm_out),
  .active_code(active_code), .started(started));

// ### testbench/pwm_load.sv
`timescale 1ns/100ps
module pwm_load (
  // Load input
  input wire sys_clk,
  input wire pwm_out,
  // Last full cycle, in clocks
  output int high_clks,
  output int period_clks
);
  int hi;
  int per;
  logic last;
  always @(posedge sys_clk) begin
    last <= pwm_out;
    per <= per + 1;
    if (pwm_out) hi <= hi + 1;
    if (pwm_out && !last) begin
      period_clks <= per;
      high_clks <= hi;
      per <= 1;
      hi <= 1;
    end
  end
endmodule

// ### testbench/divided_pwm_oscillator_tb_top.sv
`timescale 1ns/100ps
module divided_pwm_oscillator_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] code = 4'h1;
  logic rate_ok = 1'b1;
  logic [7:0] duty = 8'h80;
  logic pwm_out;
  logic [3:0] active_code;
  logic started;
  int high_clks;
  int period_clks;
  int n_errors = 0;
  int samples_checked = 0;
  int i;
  logic [31:0] seed = 32'hA5F7;
  always #10 sys_clk = ~sys_clk;
  divided_pwm_oscillator #(.BASE_DIV(50), .VERSION(2'h0)) u_divided_pwm_oscillator (
    .sys_clk(sys_clk), .nrst(nrst), .divider_select_code(code),
    .rate_set_current_ok(rate_ok), .duty_in(duty), .pwm_out(pwm_out),
    .active_code(active_code), .started(started));
  pwm_load u_pwm_load (.sys_clk(sys_clk), .pwm_out(pwm_out), .high_clks(high_clks),
    .period_clks(period_clks));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 8'(1 + seed % 192);
  endfunction
  function automatic int ratio(logic [3:0] c);
    return 1 << (2 * (c[3] ? 7 - c[2:0] : c[2:0]));
  endfunction
  function automatic int exp_high(logic [3:0] c, logic [7:0] d);
    int h = (ratio(c) * d + 255) / 256;
    return 50 * (c[3] ? ratio(c) - h : h);
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic run(logic [3:0] c, logic [7:0] d);
    code = c;
    duty = d;
    for (i = 0; i < 40000 && active_code !== c; i++) @(negedge sys_clk);
    check("adopted", c, active_code);
    repeat (3) @(posedge pwm_out);
    repeat (2) @(negedge sys_clk);
    check("period", 50 * ratio(c), period_clks);
    check("high", exp_high(c, d), high_clks);
    duty = 8'hFF;
    repeat (10) @(negedge sys_clk);
    duty = 8'h00;
    repeat (10) @(negedge sys_clk);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    check("out_low", 0, pwm_out);
    for (i = 0; i < 30000 && started !== 1'b1; i++) @(negedge sys_clk);
    check("start", 1, i >= 25000 && started);
    run(4'h1, rnd());
    run(4'hE, rnd());
    code = 4'h5;
    repeat (1000) @(negedge sys_clk);
    run(4'h2, rnd());
    rate_ok = 1'b0;
    repeat (2000) @(negedge sys_clk);
    rate_ok = 1'b1;
    print_verdict;
  end
  initial begin
    #1600000;
    n_errors++;
    print_verdict;
  end
endmodule
